// [verification/dsr_status_regs_bench.sv]
/*
 dsr_status_regs_bench: self-checking bench for the read-only status register bank.
 assumes: design package, sync interface and modules compiled first; the bench drives every pin itself.
*/
`timescale 1ns/1ps
`default_nettype none
module dsr_status_regs_bench;
   localparam logic [3:0] REV = 4'hA;  // value arbitrary
   logic       clk_sys, reset_n, wr_strobe, rd_strobe, irq;
   logic [7:0] addr, wr_data, rd_data;
   logic [2:0] link_layer_state;
   logic       service_buffer_available, line_level_cmp, line_level_ttl, aux_input_pin;
   logic       reg_overcurrent, reg_below_setpoint, reg_hiccup, reg_steady, ext_clock_bad;
   logic       aux_driver_fault, line_driver_fault_in, supply_below_fall, supply_above_rise;
   logic       monitor_below, temp_above_warn;
   logic       receive_output_level, aux_input_logic_level, master_clock_direction, external_clock_select;
   int         fails   = 0;
   int         checked = 0;
   // ctrl[5:3] cmp[2] ttl[1] expected receive level[0]
   logic [5:0]  rx_tab [7] = '{6'b000_10_1, 6'b001_10_0, 6'b001_01_1, 6'b010_10_0, 6'b010_00_1,
                               6'b100_10_0, 6'b110_00_0};
   // overcurrent, below, hiccup, steady then expected fault and power good
   logic [5:0]  reg_tab [6] = '{6'b1000_10, 6'b0100_10, 6'b0010_10, 6'b0001_01, 6'b1001_10, 6'b0000_00};
   // ctrl, {clk, aux, line, rise, fall, mon, temp}, expected status two
   logic [22:0] two_tab [13] = '{{8'h10, 7'b1000000, 8'h40}, {8'h00, 7'b1000000, 8'h00},
      {8'h18, 7'b1000000, 8'h00}, {8'h00, 7'b0100000, 8'h20}, {8'h00, 7'b0010000, 8'h10},
      {8'h00, 7'b0000010, 8'h04}, {8'h00, 7'b0000001, 8'h02}, {8'h00, 7'b0000100, 8'h08},
      {8'h00, 7'b0000000, 8'h08}, {8'h00, 7'b0001000, 8'h00}, {8'h00, 7'b0001100, 8'h08},
      {8'h00, 7'b0000000, 8'h08}, {8'h00, 7'b0001000, 8'h00}};

   dsr_status_regs #(.REVISION(REV)) i_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
      .rd_strobe(rd_strobe), .rd_data(rd_data), .irq(irq), .link_layer_state(link_layer_state),
      .service_buffer_available(service_buffer_available), .line_level_cmp(line_level_cmp),
      .line_level_ttl(line_level_ttl), .aux_input_pin(aux_input_pin), .reg_overcurrent(reg_overcurrent),
      .reg_below_setpoint(reg_below_setpoint), .reg_hiccup(reg_hiccup), .reg_steady(reg_steady),
      .ext_clock_bad(ext_clock_bad), .aux_driver_fault(aux_driver_fault),
      .line_driver_fault_in(line_driver_fault_in), .supply_below_fall(supply_below_fall),
      .supply_above_rise(supply_above_rise), .monitor_below(monitor_below), .temp_above_warn(temp_above_warn),
      .receive_output_level(receive_output_level), .aux_input_logic_level(aux_input_logic_level),
      .master_clock_direction(master_clock_direction), .external_clock_select(external_clock_select));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic results;
      if (fails == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr      <= a;
      wr_data   <= d;
      wr_strobe <= 1'b1;
      @(posedge clk_sys);
      wr_strobe <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      addr      <= a;
      rd_strobe <= 1'b1;
      @(posedge clk_sys);
      rd_strobe <= 1'b0;
      #1;
      chk(rd_data, exp);
      @(posedge clk_sys);
   endtask

   // pin levels pass a two-flop synchroniser before the status registers
   task automatic settle;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask

   initial begin
      repeat (3000) @(posedge clk_sys);
      fails++;
      results();
   end

   initial begin
      {reset_n, wr_strobe, rd_strobe, addr, wr_data, link_layer_state} = '0;
      {service_buffer_available, line_level_cmp, line_level_ttl, aux_input_pin} = '0;
      {reg_overcurrent, reg_below_setpoint, reg_hiccup, reg_steady, ext_clock_bad} = '0;
      {aux_driver_fault, line_driver_fault_in, supply_below_fall, supply_above_rise} = '0;
      {monitor_below, temp_above_warn} = '0;
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(8'h01, {4'h0, REV});
      rd(8'h02, 8'h00);
      rd(8'h05, 8'h00);
      for (int c = 0; c < 8; c++) begin
         @(posedge clk_sys);
         link_layer_state <= 3'(c);
         repeat (2) @(posedge clk_sys);
         rd(8'h02, (c > 4) ? 8'h04 : 8'(c));
      end
      service_buffer_available <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rd(8'h05, 8'h01);
      for (int a = 1; a < 6; a++) begin
         wr(8'(a), 8'hFF);
      end
      rd(8'h01, {4'h0, REV});
      rd(8'h02, 8'h04);
      rd(8'h05, 8'h01);
      rd(8'h03, 8'h00);
      service_buffer_available <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rd(8'h05, 8'h00);
      foreach (reg_tab[i]) begin
         {reg_overcurrent, reg_below_setpoint, reg_hiccup, reg_steady} <= reg_tab[i][5:2];
         settle();
         rd(8'h03, {2'b00, reg_tab[i][1:0], 4'h0});
      end
      foreach (rx_tab[i]) begin
         wr(8'h10, {5'h00, rx_tab[i][5:3]});
         {line_level_cmp, line_level_ttl} <= rx_tab[i][2:1];
         aux_input_pin <= rx_tab[i][0];
         settle();
         rd(8'h03, {6'h00, rx_tab[i][0], rx_tab[i][0]});
         chk({6'h00, receive_output_level, aux_input_logic_level}, {6'h00, {2{rx_tab[i][0]}}});
      end
      foreach (two_tab[i]) begin
         wr(8'h10, two_tab[i][22:15]);
         {ext_clock_bad, aux_driver_fault, line_driver_fault_in, supply_above_rise} <= two_tab[i][14:11];
         {supply_below_fall, monitor_below, temp_above_warn} <= two_tab[i][10:8];
         settle();
         rd(8'h04, two_tab[i][7:0]);
         chk({6'h00, external_clock_select, master_clock_direction}, {6'h00, two_tab[i][19:18]});
      end
      // interrupt: clear, enable thermal rising, raise, mask, unmask, clear
      {temp_above_warn, supply_above_rise} <= 2'b00;
      settle();
      wr(8'h12, 8'hFF);
      wr(8'h13, 8'h04);
      rd(8'h11, 8'h00);
      chk({7'h00, irq}, 8'h00);
      temp_above_warn <= 1'b1;
      settle();
      rd(8'h11, 8'h04);
      chk({7'h00, irq}, 8'h01);
      wr(8'h13, 8'h00);
      settle();
      chk({7'h00, irq}, 8'h00);
      wr(8'h13, 8'h04);
      settle();
      chk({7'h00, irq}, 8'h01);
      wr(8'h12, 8'h04);
      settle();
      chk({7'h00, irq}, 8'h00);
      rd(8'h11, 8'h00);
      rd(8'h12, 8'h00);
      rd(8'h7F, 8'h00);
      results();
   end
endmodule
`default_nettype wire

// [verilog/dsr_pkg.sv]
/*
 dsr_pkg: offsets, field positions, reset values and codes of the device status register bank.
 assumes: an 8-bit register port with byte offsets, used by the status bank; the testbench uses literal offsets.
*/
// Operation
// R1 - revision register shows a 4-bit revision in bits 3:0, bits 7:4 zero
// R2 - link state field reports idle, establishing, startup, pre-operate, operate; resets idle
// R3 - link state field never shows a code above operate
// R4 - regulator fault set on overcurrent, output below seventy percent, or hiccup
// R5 - regulator power good only in steady normal operation without fault
// R6 - receive level follows line level, ttl option and line inversion
// R7 - receive level reads zero while the receiver is disabled
// R8 - aux input level bit follows the aux input pin
// R9 - external clock fail only with clock pin input and external clock selected
// R10 - aux output fault bit follows the aux driver fault
// R11 - line driver fault bit follows the line driver fault
// R12 - supply undervoltage sets below falling threshold, clears above rising threshold
// R13 - monitored input bit is one while the monitored input is low
// R14 - thermal warning bit is one while the die is above warning threshold
// R15 - service buffer bit shows buffer readable by host; resets to zero
// R16 - writes to read-only registers change nothing; unused bits read zero
package dsr_pkg;

   // register offsets
   localparam logic [7:0] OFS_REVISION  = 8'h01;
   localparam logic [7:0] OFS_LINK      = 8'h02;
   localparam logic [7:0] OFS_DEV_ONE   = 8'h03;
   localparam logic [7:0] OFS_DEV_TWO   = 8'h04;
   localparam logic [7:0] OFS_ISDU      = 8'h05;
   localparam logic [7:0] OFS_CTRL      = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h11;
   localparam logic [7:0] OFS_IRQ_CLR   = 8'h12;
   localparam logic [7:0] OFS_IRQ_EN    = 8'h13;

   // link layer state codes
   localparam logic [2:0] LINK_IDLE        = 3'h0;
   localparam logic [2:0] LINK_ESTABLISH   = 3'h1;
   localparam logic [2:0] LINK_STARTUP     = 3'h2;
   localparam logic [2:0] LINK_PRE_OPERATE = 3'h3;
   localparam logic [2:0] LINK_OPERATE     = 3'h4;

   // device status one bit positions
   localparam int B1_REG_FAULT = 5;
   localparam int B1_REG_GOOD  = 4;
   localparam int B1_RX_LEVEL  = 1;
   localparam int B1_AUX_LEVEL = 0;

   // device status two bit positions
   localparam int B2_EXT_CLK   = 6;
   localparam int B2_AUX_FAULT = 5;
   localparam int B2_LINE_FLT  = 4;
   localparam int B2_UNDERVOLT = 3;
   localparam int B2_MON_LOW   = 2;
   localparam int B2_THERMAL   = 1;

   // interrupt status bit positions
   localparam int EV_LINK_CHANGE = 0;
   localparam int EV_BUFFER      = 1;

   // synchronised pin inputs
   localparam int SY_LINE_CMP  = 0;
   localparam int SY_LINE_TTL  = 1;
   localparam int SY_AUX_IN    = 2;
   localparam int SY_REG_OC    = 3;
   localparam int SY_REG_LOW   = 4;
   localparam int SY_REG_HIC   = 5;
   localparam int SY_REG_STDY  = 6;
   localparam int SY_CLK_BAD   = 7;
   localparam int SY_AUX_FLT   = 8;
   localparam int SY_LINE_FLT  = 9;
   localparam int SY_UV_FALL   = 10;
   localparam int SY_UV_RISE   = 11;
   localparam int SY_MON_LOW   = 12;
   localparam int SY_TEMP_WARN = 13;
   localparam int SY_WIDTH     = 14;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [4:0] RST_CTRL = 5'h00;

   typedef struct packed {
      logic ext_clock_sel;
      logic clock_dir;
      logic rx_disable;
      logic inversion;
      logic ttl_option;
   } dsr_ctrl_t;

endpackage

// [verilog/dsr_status_regs.sv]
/*
 dsr_status_regs: read-only identification and status bank with control and interrupt registers.
 assumes: host port with one-cycle strobes; status conditions arrive as pin levels from analog blocks;
 link state and buffer flag come from logic on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module dsr_status_regs #(
   parameter logic [3:0] REVISION = 4'h5  // value arbitrary
) (
   input  wire logic       clk_sys,                    // system clock, 10 MHz
   input  wire logic       reset_n,                    // asynchronous reset, active low
   input  wire logic [7:0] addr,                       // register offset
   input  wire logic [7:0] wr_data,                    // write data
   input  wire logic       wr_strobe,                  // write strobe
   input  wire logic       rd_strobe,                  // read strobe
   output logic      [7:0] rd_data,                    // read data, cycle after strobe
   output logic            irq,                        // interrupt level
   input  wire logic [2:0] link_layer_state,           // present link state
   input  wire logic       service_buffer_available,   // isdu buffer readable
   input  wire logic       line_level_cmp,             // line pin comparator level
   input  wire logic       line_level_ttl,             // line pin ttl level
   input  wire logic       aux_input_pin,              // aux digital input pin
   input  wire logic       reg_overcurrent,            // regulator overcurrent or overload
   input  wire logic       reg_below_setpoint,         // regulator output under 70 percent
   input  wire logic       reg_hiccup,                 // regulator in hiccup mode
   input  wire logic       reg_steady,                 // regulator in steady state
   input  wire logic       ext_clock_bad,              // clock pin missing or wrong rate
   input  wire logic       aux_driver_fault,           // aux driver overcurrent or thermal
   input  wire logic       line_driver_fault_in,       // line driver overcurrent or thermal
   input  wire logic       supply_below_fall,          // field supply under falling threshold
   input  wire logic       supply_above_rise,          // field supply over rising threshold
   input  wire logic       monitor_below,              // monitored input under threshold
   input  wire logic       temp_above_warn,            // die above warning threshold
   output logic            receive_output_level,       // receive output level
   output logic            aux_input_logic_level,      // aux input output level
   output logic            master_clock_direction,     // clock pin direction setting
   output logic            external_clock_select       // external clock selected
);

   typedef struct packed {
      logic [2:0]        link;
      logic [7:0]        dev1;
      logic [7:0]        dev2;
      logic              isdu;
      dsr_pkg::dsr_ctrl_t ctrl;
      logic [7:0]        irq_stat;
      logic [7:0]        irq_en;
      logic [7:0]        rd_data;
      logic              irq;
   } dsr_state_t;

   dsr_state_t st_r;
   dsr_state_t st_nxt;
   logic [1:0] rst_sync_r;
   logic       rst_n;

   // reset release through two flops
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   dsr_sync_if #(.W(dsr_pkg::SY_WIDTH)) sif ();

   assign sif.async_in = {temp_above_warn, monitor_below, supply_above_rise, supply_below_fall,
                          line_driver_fault_in, aux_driver_fault, ext_clock_bad, reg_steady,
                          reg_hiccup, reg_below_setpoint, reg_overcurrent, aux_input_pin,
                          line_level_ttl, line_level_cmp};

   dsr_sync #(.W(dsr_pkg::SY_WIDTH)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .bus     (sif.syncer)
   );

   function automatic logic [7:0] read_mux(input logic [7:0] a, input dsr_state_t s);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         dsr_pkg::OFS_REVISION: v = {4'h0, REVISION};  // R1
         dsr_pkg::OFS_LINK:     v = {5'h00, s.link};
         dsr_pkg::OFS_DEV_ONE:  v = s.dev1;
         dsr_pkg::OFS_DEV_TWO:  v = s.dev2;
         dsr_pkg::OFS_ISDU:     v = {7'h00, s.isdu};
         dsr_pkg::OFS_CTRL:     v = {3'h0, s.ctrl};
         dsr_pkg::OFS_IRQ_STAT: v = s.irq_stat;
         dsr_pkg::OFS_IRQ_EN:   v = s.irq_en;
         default:               v = 8'h00;  // R16
      endcase
      return v;
   endfunction

   always_comb begin
      logic [dsr_pkg::SY_WIDTH-1:0] s;
      logic                         rx_sel;
      logic [7:0]                   ev;
      logic [7:0]                   clr;
      s      = sif.sync_out;
      rx_sel = 1'b0;
      ev     = 8'h00;
      clr    = 8'h00;
      st_nxt = st_r;

      // device status one, unused bits zero
      st_nxt.dev1 = 8'h00;
      st_nxt.dev1[dsr_pkg::B1_REG_FAULT] = s[dsr_pkg::SY_REG_OC] | s[dsr_pkg::SY_REG_LOW] |
                                           s[dsr_pkg::SY_REG_HIC];  // R4
      st_nxt.dev1[dsr_pkg::B1_REG_GOOD] = s[dsr_pkg::SY_REG_STDY] &
                                          ~st_nxt.dev1[dsr_pkg::B1_REG_FAULT];  // R5
      rx_sel = st_r.ctrl.ttl_option ? s[dsr_pkg::SY_LINE_TTL] : s[dsr_pkg::SY_LINE_CMP];
      st_nxt.dev1[dsr_pkg::B1_RX_LEVEL] = ~st_r.ctrl.rx_disable &  // R7
                                          (rx_sel ^ st_r.ctrl.inversion);  // R6
      st_nxt.dev1[dsr_pkg::B1_AUX_LEVEL] = s[dsr_pkg::SY_AUX_IN];  // R8

      // device status two
      st_nxt.dev2 = 8'h00;
      st_nxt.dev2[dsr_pkg::B2_EXT_CLK] = ~st_r.ctrl.clock_dir & st_r.ctrl.ext_clock_sel &
                                         s[dsr_pkg::SY_CLK_BAD];  // R9
      st_nxt.dev2[dsr_pkg::B2_AUX_FAULT] = s[dsr_pkg::SY_AUX_FLT];  // R10
      st_nxt.dev2[dsr_pkg::B2_LINE_FLT] = s[dsr_pkg::SY_LINE_FLT];  // R11
      if (s[dsr_pkg::SY_UV_FALL]) begin
         st_nxt.dev2[dsr_pkg::B2_UNDERVOLT] = 1'b1;  // R12
      end else if (s[dsr_pkg::SY_UV_RISE]) begin
         st_nxt.dev2[dsr_pkg::B2_UNDERVOLT] = 1'b0;  // R12
      end else begin
         st_nxt.dev2[dsr_pkg::B2_UNDERVOLT] = st_r.dev2[dsr_pkg::B2_UNDERVOLT];  // R12
      end
      st_nxt.dev2[dsr_pkg::B2_MON_LOW] = s[dsr_pkg::SY_MON_LOW];  // R13
      st_nxt.dev2[dsr_pkg::B2_THERMAL] = s[dsr_pkg::SY_TEMP_WARN];  // R14

      // invalid link codes keep the last valid state
      if (link_layer_state <= dsr_pkg::LINK_OPERATE) begin
         st_nxt.link = link_layer_state;  // R2 R3
      end
      st_nxt.isdu = service_buffer_available;  // R15

      // events: link change, buffer ready, rising status two faults
      ev[dsr_pkg::EV_LINK_CHANGE] = (st_nxt.link != st_r.link);
      ev[dsr_pkg::EV_BUFFER]      = st_nxt.isdu & ~st_r.isdu;
      ev[7:2] = st_nxt.dev2[6:1] & ~st_r.dev2[6:1];

      // only own registers take writes
      if (wr_strobe) begin
         case (addr)
            dsr_pkg::OFS_CTRL:    st_nxt.ctrl = wr_data[4:0];
            dsr_pkg::OFS_IRQ_EN:  st_nxt.irq_en = wr_data;
            dsr_pkg::OFS_IRQ_CLR: clr = wr_data;
            default:              clr = 8'h00;  // R16
         endcase
      end
      // set wins over clear
      st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;
      st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_en);
      st_nxt.rd_data  = rd_strobe ? read_mux(addr, st_r) : 8'h00;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r          <= '0;
         st_r.link     <= dsr_pkg::LINK_IDLE;  // R2
         st_r.dev1     <= dsr_pkg::RST_BYTE;
         st_r.dev2     <= dsr_pkg::RST_BYTE;
         st_r.isdu     <= 1'b0;  // R15
         st_r.ctrl     <= dsr_pkg::RST_CTRL;
         st_r.irq_stat <= dsr_pkg::RST_BYTE;
         st_r.irq_en   <= dsr_pkg::RST_BYTE;
         st_r.rd_data  <= dsr_pkg::RST_BYTE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_data                = st_r.rd_data;
   assign irq                    = st_r.irq;
   assign receive_output_level   = st_r.dev1[dsr_pkg::B1_RX_LEVEL];
   assign aux_input_logic_level  = st_r.dev1[dsr_pkg::B1_AUX_LEVEL];
   assign master_clock_direction = st_r.ctrl.clock_dir;
   assign external_clock_select  = st_r.ctrl.ext_clock_sel;

   // checks
   property p_rev_read;
      @(posedge clk_sys) disable iff (!rst_n)
      rd_strobe && addr == dsr_pkg::OFS_REVISION |=> rd_data == {4'h0, REVISION};
   endproperty
   a_rev_read: assert property (p_rev_read) else $error("revision read wrong");  // R1

   property p_link_follow;
      @(posedge clk_sys) disable iff (!rst_n)
      link_layer_state <= dsr_pkg::LINK_OPERATE |=> st_r.link == $past(link_layer_state);
   endproperty
   a_link_follow: assert property (p_link_follow) else $error("link state not followed");  // R2

   property p_link_legal;
      @(posedge clk_sys) disable iff (!rst_n)
      rd_strobe && addr == dsr_pkg::OFS_LINK |=> rd_data <= {5'h00, dsr_pkg::LINK_OPERATE};
   endproperty
   a_link_legal: assert property (p_link_legal) else $error("illegal link code read");  // R3

   property p_link_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      link_layer_state > dsr_pkg::LINK_OPERATE |=> $stable(st_r.link);
   endproperty
   a_link_hold: assert property (p_link_hold) else $error("illegal link code taken");  // R3

   property p_good_fault;
      @(posedge clk_sys) disable iff (!rst_n)
      st_r.dev1[dsr_pkg::B1_REG_FAULT] |-> !st_r.dev1[dsr_pkg::B1_REG_GOOD];
   endproperty
   a_good_fault: assert property (p_good_fault) else $error("power good with fault");  // R5

   property p_reg_fault;
      @(posedge clk_sys) disable iff (!rst_n)
      reg_hiccup [*3] |=> st_r.dev1[dsr_pkg::B1_REG_FAULT];
   endproperty
   a_reg_fault: assert property (p_reg_fault) else $error("hiccup not reported");  // R4

   property p_rx_disabled;
      @(posedge clk_sys) disable iff (!rst_n)
      st_r.ctrl.rx_disable |=> !receive_output_level;
   endproperty
   a_rx_disabled: assert property (p_rx_disabled) else $error("receive level while disabled");  // R7

   property p_rx_invert;
      @(posedge clk_sys) disable iff (!rst_n)
      !st_r.ctrl.rx_disable && !st_r.ctrl.ttl_option && st_r.ctrl.inversion && line_level_cmp [*4]
      |=> !receive_output_level;
   endproperty
   a_rx_invert: assert property (p_rx_invert) else $error("inversion not applied");  // R6

   property p_aux_level;
      @(posedge clk_sys) disable iff (!rst_n)
      aux_input_pin [*4] |=> aux_input_logic_level;
   endproperty
   a_aux_level: assert property (p_aux_level) else $error("aux level not followed");  // R8

   property p_ext_clk;
      @(posedge clk_sys) disable iff (!rst_n)
      !st_r.ctrl.ext_clock_sel |=> !st_r.dev2[dsr_pkg::B2_EXT_CLK];
   endproperty
   a_ext_clk: assert property (p_ext_clk) else $error("clock fail with internal clock");  // R9

   property p_uv_hyst;
      @(posedge clk_sys) disable iff (!rst_n)
      !supply_below_fall && !supply_above_rise [*4] |=> $stable(st_r.dev2[dsr_pkg::B2_UNDERVOLT]);
   endproperty
   a_uv_hyst: assert property (p_uv_hyst) else $error("undervoltage moved inside band");  // R12

   property p_uv_set;
      @(posedge clk_sys) disable iff (!rst_n)
      supply_below_fall [*4] |=> st_r.dev2[dsr_pkg::B2_UNDERVOLT];
   endproperty
   a_uv_set: assert property (p_uv_set) else $error("undervoltage not set");  // R12

   property p_buffer;
      @(posedge clk_sys) disable iff (!rst_n)
      rd_strobe && addr == dsr_pkg::OFS_ISDU ##1 1'b1 |-> rd_data == {7'h00, $past(st_r.isdu)};
   endproperty
   a_buffer: assert property (p_buffer) else $error("buffer bit read wrong");  // R15

   property p_ro_write;
      @(posedge clk_sys) disable iff (!rst_n)
      wr_strobe && addr == dsr_pkg::OFS_DEV_TWO |=> st_r.ctrl == $past(st_r.ctrl)
         && st_r.irq_en == $past(st_r.irq_en);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write had effect");  // R16

   property p_unmapped;
      @(posedge clk_sys) disable iff (!rst_n)
      rd_strobe && addr > dsr_pkg::OFS_IRQ_EN |=> rd_data == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");  // R16

   property p_set_wins;
      @(posedge clk_sys) disable iff (!rst_n)
      st_nxt.link != st_r.link && wr_strobe && addr == dsr_pkg::OFS_IRQ_CLR
      |=> st_r.irq_stat[dsr_pkg::EV_LINK_CHANGE];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

   property p_irq_level;
      @(posedge clk_sys) disable iff (!rst_n)
      irq |-> |(st_r.irq_stat & st_r.irq_en);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt without enabled cause");

   property p_good_steady;
      @(posedge clk_sys) disable iff (!rst_n)
      reg_steady && !reg_overcurrent && !reg_below_setpoint && !reg_hiccup [*4]
      |=> st_r.dev1[dsr_pkg::B1_REG_GOOD];
   endproperty
   a_good_steady: assert property (p_good_steady) else $error("power good missing");  // R5

   property p_rx_ttl;
      @(posedge clk_sys) disable iff (!rst_n)
      !st_r.ctrl.rx_disable && st_r.ctrl.ttl_option && !st_r.ctrl.inversion && line_level_ttl [*4]
      |=> receive_output_level;
   endproperty
   a_rx_ttl: assert property (p_rx_ttl) else $error("ttl level not followed");  // R6

   property p_ext_clk_set;
      @(posedge clk_sys) disable iff (!rst_n)
      !st_r.ctrl.clock_dir && st_r.ctrl.ext_clock_sel && ext_clock_bad [*4]
      |=> st_r.dev2[dsr_pkg::B2_EXT_CLK];
   endproperty
   a_ext_clk_set: assert property (p_ext_clk_set) else $error("clock fail not reported");  // R9

   property p_aux_fault;
      @(posedge clk_sys) disable iff (!rst_n)
      aux_driver_fault [*4] |=> st_r.dev2[dsr_pkg::B2_AUX_FAULT];
   endproperty
   a_aux_fault: assert property (p_aux_fault) else $error("aux fault not reported");  // R10

   property p_line_fault;
      @(posedge clk_sys) disable iff (!rst_n)
      line_driver_fault_in [*4] |=> st_r.dev2[dsr_pkg::B2_LINE_FLT];
   endproperty
   a_line_fault: assert property (p_line_fault) else $error("line fault not reported");  // R11

   property p_mon_low;
      @(posedge clk_sys) disable iff (!rst_n)
      monitor_below [*4] |=> st_r.dev2[dsr_pkg::B2_MON_LOW];
   endproperty
   a_mon_low: assert property (p_mon_low) else $error("monitored input low not reported");  // R13

   property p_thermal;
      @(posedge clk_sys) disable iff (!rst_n)
      temp_above_warn [*4] |=> st_r.dev2[dsr_pkg::B2_THERMAL];
   endproperty
   a_thermal: assert property (p_thermal) else $error("thermal warning not reported");  // R14

   property p_isdu_follow;
      @(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> st_r.isdu == $past(service_buffer_available);
   endproperty
   a_isdu_follow: assert property (p_isdu_follow) else $error("buffer bit not followed");  // R15

   c_operate:  cover property (@(posedge clk_sys) disable iff (!rst_n)
                               st_r.link == dsr_pkg::LINK_OPERATE);
   c_irq:      cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(irq));
   c_rx_high:  cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(receive_output_level));
   c_uv:       cover property (@(posedge clk_sys) disable iff (!rst_n)
                               $rose(st_r.dev2[dsr_pkg::B2_UNDERVOLT]));
endmodule
`default_nettype wire

// [verilog/dsr_sync.sv]
/*
 dsr_sync: two flip-flop synchroniser bank of parameterised width.
 assumes: inputs are asynchronous levels; reset already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
module dsr_sync #(
   parameter int W = 1
) (
   input  wire logic   clk_sys,  // system clock
   input  wire logic   rst_n,    // synchronised reset, active low
   dsr_sync_if.syncer  bus       // raw levels in, synced levels out
);
   if (W < 1) begin : g_chk
      $error("dsr_sync width must be at least one");
   end

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dsr_sync_st_t;

   dsr_sync_st_t st_r;
   dsr_sync_st_t st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = bus.async_in;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.sync_out = st_r.s2;
endmodule
`default_nettype wire

// [verilog/dsr_sync_if.sv]
/*
 dsr_sync_if: raw pin levels into the synchroniser and their clocked copies back.
 assumes: one clock domain on the receiving side.
*/
`timescale 1ns/1ps
`default_nettype none
interface dsr_sync_if #(parameter int W = 1);
   logic [W-1:0] async_in;
   logic [W-1:0] sync_out;
   modport owner  (output async_in, input sync_out);
   modport syncer (input async_in, output sync_out);
endinterface
`default_nettype wire
